// ### dbgp_consts.vh
`ifndef DBGP_CONSTS_VH
`define DBGP_CONSTS_VH
// Link frame: command byte then data byte, both shifted MSB first on rising clock edges.
`define DBGP_BYTE_BITS 4'h8
`define DBGP_CNT_W 4
// Command codes carried in the first byte of a frame.
`define DBGP_CMD_CONNECT 8'hA5
`define DBGP_CMD_DISCONNECT 8'h5A
`define DBGP_CMD_RESET 8'hC3
`define DBGP_CMD_LED_BLOCK 8'h3C
`define DBGP_CMD_READ 8'h96
// Reply byte returned on a read: status in the low bits.
`define DBGP_STAT_W 8
// Lifecycle state of the part.
`define DBGP_LIFE_FACTORY 2'h0
`define DBGP_LIFE_USER 2'h1
`define DBGP_LIFE_RUN 2'h2
// Idle time without a rising clock edge that aborts a frame, in ns.
`define DBGP_IDLE_NS 20000
`define DBGP_CLK_MHZ 100
// Length of the digital reset pulse in cycles.
`define DBGP_RST_CYC 8'h10
`endif

// ### dbgp_sync.v
`timescale 1ns/100ps
`default_nettype none
// Three-stage pin synchroniser; the output changes once stages two and three agree.
module dbgp_sync (
   // Clock and reset.
   input wire mclk,
   input wire reset_n,
   // Asynchronous pin and filtered level.
   input wire pin_in,
   output reg level_out,
   // One-cycle pulse on a filtered rising edge.
   output reg rise_out
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   // Stage one feeds only stage two; the filter looks at stages two and three.
   always @(posedge mclk) begin
      if (!reset_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_out <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         rise_out <= 1'b0;
         if (s2_r == s3_r && s3_r != level_out) begin
            level_out <= s3_r;
            rise_out <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

// ### dbgp_core.v
`timescale 1ns/100ps
`default_nettype none
`include "dbgp_consts.vh"
// What this block does
// [RULE_01] Link is a host-driven clock line plus one shared bidirectional data line.
// [RULE_02] Fully programmed parts can switch the debug port off entirely by user setting.
// [RULE_03] Debug traffic runs while the core is halted, peripherals and software stalled.
// [RULE_04] Debug clock borrows pin 5, debug data borrows pin 4.
// [RULE_05] LED current sink also drives pin 5, sharing it with debug clock.
// [RULE_06] During a session the LED driver stays off whatever software asks.
// [RULE_07] Host clears breakpoints and LED block on disconnect, then lets device run.
// [RULE_08] After disconnect execution resumes where it halted, not at reset vector.
// [RULE_09] A new connection only succeeds while the LED driver is inactive.
// [RULE_10] Host blocks the LED right after connecting, until disconnection.
// [RULE_11] Outside debug transactions pin 4 stays a user bidirectional pin.
// [RULE_12] Host reset command resets the digital section and starts boot.
// [RULE_13] Debug reset returns all registers to initial state, reloads factory values.
// [RULE_14] Factory parts keep code/data RAM contents across a debug reset.
// [RULE_15] User parts reload customer data region into code/data RAM on debug reset.
// [RULE_16] Shutdown removes digital power, erasing RAM; a grounded input wakes it.
// [RULE_17] Run-only parts refuse all debug access.
// [RULE_18] Device drives the data pin only while returning reply data.
module dbgp_core #(
   parameter IDLE_CYC = (`DBGP_IDLE_NS * `DBGP_CLK_MHZ) / 1000
) (
   // Clock and reset.
   input wire mclk,
   input wire reset_n,
   // Debug clock pin (pin 5 input side) and data pin (pin 4).
   input wire debug_clock_line,
   input wire debug_data_line_in,
   output reg debug_data_line_out,
   output reg debug_data_line_oe,
   // User side of pin 4.
   input wire user_pin4_out,
   input wire user_pin4_oe,
   output reg user_pin4_in,
   // LED request from software and sink drive onto pin 5.
   input wire led_request,
   output reg led_sink_on,
   // Part lifecycle and user disable of the port.
   input wire [1:0] life_state,
   input wire debug_disable,
   // Shutdown request and wake inputs.
   input wire shutdown_req,
   input wire wake_any_low,
   output reg digital_power_on,
   // Core control.
   output reg core_halt,
   output reg digital_reset,
   output reg boot_start,
   output reg boot_load_user,
   output reg session_active
);
   localparam [2:0] ST_CMD = 3'b001;
   localparam [2:0] ST_DATA = 3'b010;
   localparam [2:0] ST_REPLY = 3'b100;
   localparam CNT_W = 32;

   wire clk_lvl;
   wire clk_rise;
   wire dat_lvl;
   reg [2:0] state_r;
   reg [`DBGP_CNT_W-1:0] bit_r;
   reg [7:0] cmd_r;
   reg [7:0] shift_r;
   reg [CNT_W-1:0] idle_r;
   reg led_block_r;
   reg [7:0] rst_r;
   reg clk_lvl_d_r;
   wire port_ok;
   wire clk_fall;

   // Pins from the adapter are asynchronous; both pass the three-stage filter. [RULE_04]
   dbgp_sync u_clk (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in(debug_clock_line),
      .level_out(clk_lvl),
      .rise_out(clk_rise)
   );
   dbgp_sync u_dat (
      .mclk(mclk),
      .reset_n(reset_n),
      .pin_in(debug_data_line_in),
      .level_out(dat_lvl),
      .rise_out()
   );

   // Run parts and user-disabled programmed parts ignore the link. [RULE_17] [RULE_02]
   assign port_ok = (life_state != `DBGP_LIFE_RUN) && !(life_state == `DBGP_LIFE_USER && debug_disable);
   assign clk_fall = clk_lvl_d_r && !clk_lvl;

   // Frame decoder: command byte, data byte, optional reply byte. [RULE_01]
   always @(posedge mclk) begin
      if (!reset_n) begin
         state_r <= ST_CMD;
         bit_r <= {`DBGP_CNT_W{1'b0}};
         cmd_r <= 8'h00;
         shift_r <= 8'h00;
         idle_r <= {CNT_W{1'b0}};
         clk_lvl_d_r <= 1'b0;
         core_halt <= 1'b0;
         session_active <= 1'b0;
         led_block_r <= 1'b0;
         rst_r <= 8'h00;
         debug_data_line_out <= 1'b0;
         debug_data_line_oe <= 1'b0;
      end else begin
         clk_lvl_d_r <= clk_lvl;
         if (rst_r != 8'h00) begin
            rst_r <= rst_r - 8'h01;
         end
         // A stalled link aborts the partial frame and frees the data pin.
         if (clk_rise) begin
            idle_r <= {CNT_W{1'b0}};
         end else if (idle_r >= IDLE_CYC[CNT_W-1:0]) begin
            state_r <= ST_CMD;
            bit_r <= {`DBGP_CNT_W{1'b0}};
            debug_data_line_oe <= 1'b0; // [RULE_18]
         end else begin
            idle_r <= idle_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (!port_ok) begin
            state_r <= ST_CMD;
            session_active <= 1'b0;
            core_halt <= 1'b0;
            led_block_r <= 1'b0;
            debug_data_line_oe <= 1'b0; // [RULE_17]
         end else if (clk_rise) begin
            case (state_r)
               ST_CMD: begin
                  shift_r <= {shift_r[6:0], dat_lvl};
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == `DBGP_BYTE_BITS - 4'h1) begin
                     cmd_r <= {shift_r[6:0], dat_lvl};
                     bit_r <= {`DBGP_CNT_W{1'b0}};
                     state_r <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  shift_r <= {shift_r[6:0], dat_lvl};
                  bit_r <= bit_r + 4'h1;
                  if (bit_r == `DBGP_BYTE_BITS - 4'h1) begin
                     bit_r <= {`DBGP_CNT_W{1'b0}};
                     state_r <= ST_CMD;
                     if (cmd_r == `DBGP_CMD_CONNECT && !led_request) begin
                        // Connect only while the LED is dark; core halts. [RULE_09] [RULE_03]
                        session_active <= 1'b1;
                        core_halt <= 1'b1;
                     end else if (session_active) begin
                        if (cmd_r == `DBGP_CMD_DISCONNECT) begin
                           // Release halt and LED block; no reset, so the core resumes in place. [RULE_08] [RULE_07]
                           session_active <= 1'b0;
                           core_halt <= 1'b0;
                           led_block_r <= 1'b0;
                        end else if (cmd_r == `DBGP_CMD_LED_BLOCK) begin
                           led_block_r <= dat_lvl; // [RULE_10]
                        end else if (cmd_r == `DBGP_CMD_RESET) begin
                           rst_r <= `DBGP_RST_CYC; // [RULE_12]
                        end else if (cmd_r == `DBGP_CMD_READ) begin
                           shift_r <= {4'h0, led_block_r, core_halt, life_state};
                           state_r <= ST_REPLY;
                        end
                     end
                  end
               end
               ST_REPLY: begin
                  bit_r <= bit_r + 4'h1;
                  shift_r <= {shift_r[6:0], 1'b0};
                  if (bit_r == `DBGP_BYTE_BITS) begin
                     bit_r <= {`DBGP_CNT_W{1'b0}};
                     state_r <= ST_CMD;
                  end
               end
               default: state_r <= ST_CMD;
            endcase
         end
         // Reply bits change on falling clock edges; drive only in reply. [RULE_18]
         if (state_r == ST_REPLY && port_ok && bit_r != `DBGP_BYTE_BITS) begin
            if (clk_fall) begin
               debug_data_line_oe <= 1'b1;
               debug_data_line_out <= shift_r[7];
            end
         end else begin
            debug_data_line_oe <= 1'b0;
            debug_data_line_out <= 1'b0;
         end
      end
   end

   // Reset pulse, boot and RAM reload selection by lifecycle. [RULE_13] [RULE_14] [RULE_15]
   always @(posedge mclk) begin
      if (!reset_n) begin
         digital_reset <= 1'b0;
         boot_start <= 1'b0;
         boot_load_user <= 1'b0;
      end else begin
         digital_reset <= (rst_r != 8'h00); // [RULE_13]
         boot_start <= (rst_r == 8'h01); // [RULE_12]
         if (rst_r == 8'h01) begin
            boot_load_user <= (life_state == `DBGP_LIFE_USER); // [RULE_15] [RULE_14]
         end
      end
   end

   // Pin sharing: LED sink on pin 5 gated in session; pin 4 returned to user. [RULE_05] [RULE_06] [RULE_11]
   always @(posedge mclk) begin
      if (!reset_n) begin
         led_sink_on <= 1'b0;
         user_pin4_in <= 1'b0;
         digital_power_on <= 1'b1;
      end else begin
         led_sink_on <= led_request && !session_active && !led_block_r; // [RULE_06] [RULE_04]
         user_pin4_in <= dat_lvl; // [RULE_11]
         // Power drops on shutdown, RAM is lost; a grounded input restores it. [RULE_16]
         if (!digital_power_on && wake_any_low) begin
            digital_power_on <= 1'b1;
         end else if (shutdown_req) begin
            digital_power_on <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### dbgp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "dbgp_consts.vh"
// Watches the debug port at the core's pins, all on mclk.
module dbgp_monitor (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset_n,
   // Pins and core controls.
   input wire logic debug_data_line_oe,
   input wire logic led_sink_on,
   input wire logic [1:0] life_state,
   input wire logic shutdown_req,
   input wire logic digital_power_on,
   input wire logic core_halt,
   input wire logic digital_reset,
   input wire logic boot_start,
   input wire logic boot_load_user,
   input wire logic session_active
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // Counts the reset pulse; it clears when the pulse drops.
   reg [7:0] rst_len_r;
   always @(posedge mclk) begin
      if (!reset_n || !digital_reset) begin
         rst_len_r <= 8'h00;
      end else begin
         rst_len_r <= rst_len_r + 8'h01;
      end
   end
   sequence s_reset_end;
      $fell(digital_reset);
   endsequence
   a_reset_len: assert property (s_reset_end |-> rst_len_r == 8'h10)
      else $error("reset pulse length");
   a_boot_after: assert property (s_reset_end |-> $past(boot_start))
      else $error("no boot after reset");
   a_boot_pulse: assert property (boot_start |=> !boot_start)
      else $error("boot pulse too long");
   a_boot_image: assert property (boot_start |-> boot_load_user == (life_state == `DBGP_LIFE_USER))
      else $error("wrong boot image");
   a_led_blocked: assert property (session_active && $past(session_active) |-> !led_sink_on)
      else $error("led lit in session");
   a_connect_dark: assert property ($rose(session_active) |-> !$past(led_sink_on))
      else $error("connect with led lit");
   a_halt_session: assert property ($rose(session_active) |-> ##[0:1] core_halt)
      else $error("session without halt");
   a_run_locked: assert property (life_state == `DBGP_LIFE_RUN |-> !debug_data_line_oe && !$rose(session_active))
      else $error("run part answered");
   a_oe_session: assert property (debug_data_line_oe |-> session_active)
      else $error("data driven outside session");
   a_power_cause: assert property ($fell(digital_power_on) |-> $past(shutdown_req))
      else $error("power lost unasked");
endmodule
bind dbgp_core dbgp_monitor mon (.mclk, .reset_n, .debug_data_line_oe, .led_sink_on, .life_state, .shutdown_req,
   .digital_power_on, .core_halt, .digital_reset, .boot_start, .boot_load_user, .session_active);
`default_nettype wire

// ### dbgp_host.sv
`timescale 1ns/100ps
`default_nettype none
// Debug adapter: owns the link clock, which idles low between frames.
module dbgp_host (
   // Clock and sensed data pin.
   input wire logic mclk,
   input wire logic dat_level,
   // Link clock and data drive.
   output logic clk_out,
   output logic dat_oe,
   output logic dat_val
);
   initial begin
      clk_out = 1'b0;
      dat_oe = 1'b0;
      dat_val = 1'b0;
   end
   // Half of the 160 ns link period.
   task automatic half;
      repeat (8) @(posedge mclk);
   endtask
   // Command and data MSB first; a read releases the line and samples eight reply bits.
   task automatic frame(input [7:0] cmd, input [7:0] arg, input logic rd, output [7:0] reply);
      logic [15:0] word;
      word = {cmd, arg};
      reply = 8'h00;
      @(posedge mclk);
      for (int i = 15; i >= 0; i--) begin
         dat_oe <= 1'b1;
         dat_val <= word[i];
         half();
         clk_out <= 1'b1;
         half();
         clk_out <= 1'b0;
      end
      dat_oe <= 1'b0;
      for (int i = 7; i >= -1; i--) begin
         if (rd) begin
            half();
            clk_out <= 1'b1;
            if (i >= 0) reply[i] = dat_level;
            half();
            clk_out <= 1'b0;
         end
      end
      half();
   endtask
endmodule
`default_nettype wire

// ### tb_dbgp_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "dbgp_consts.vh"
// Drives the port through the adapter model and checks the pins.
module tb_dbgp_core;
   logic mclk, reset_n, led_request, debug_disable, shutdown_req, wake_any_low, user_pin4_out, user_pin4_oe;
   logic [1:0] life_state;
   logic [7:0] rep;
   wire logic debug_clock_line, debug_data_line_out, debug_data_line_oe, user_pin4_in, led_sink_on, pin4;
   wire logic digital_power_on, core_halt, digital_reset, boot_start, boot_load_user, session_active, h_oe, h_val;
   int error_cnt = 0;
   int comparisons = 0;
   // Pin 4: device, then adapter, then user; the pull-up wins when nobody drives.
   assign pin4 = debug_data_line_oe ? debug_data_line_out : h_oe ? h_val : user_pin4_oe ? user_pin4_out : 1'b1;
   dbgp_core #(.IDLE_CYC(50)) dut (.mclk, .reset_n, .debug_clock_line, .debug_data_line_in(pin4),
      .debug_data_line_out, .debug_data_line_oe, .user_pin4_out, .user_pin4_oe, .user_pin4_in, .led_request,
      .led_sink_on, .life_state, .debug_disable, .shutdown_req, .wake_any_low, .digital_power_on, .core_halt,
      .digital_reset, .boot_start, .boot_load_user, .session_active);
   dbgp_host host (.mclk, .dat_level(pin4), .clk_out(debug_clock_line), .dat_oe(h_oe), .dat_val(h_val));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task chk(input string nm, input [7:0] e, input [7:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wrap_up;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task send(input [7:0] c, input [7:0] a);
      host.frame(c, a, 1'b0, rep);
      #1;
   endtask
   // Bounded wait on boot_start, power or the pin 4 level.
   task wait_on(input int s, input logic v);
      int n;
      n = 0;
      while ((s == 0 ? boot_start : s == 1 ? digital_power_on : user_pin4_in) !== v) begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 400) begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask
   initial begin
      {reset_n, led_request, debug_disable, shutdown_req, wake_any_low, user_pin4_out, user_pin4_oe} = 7'h00;
      life_state = 2'h0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      led_request <= 1'b1;
      send(`DBGP_CMD_CONNECT, 8'h00);
      chk("session", 8'h00, session_active);
      chk("led", 8'h01, led_sink_on);
      @(posedge mclk);
      led_request <= 1'b0;
      send(`DBGP_CMD_CONNECT, 8'h00);
      chk("session", 8'h01, session_active);
      chk("halt", 8'h01, core_halt);
      @(posedge mclk);
      led_request <= 1'b1;
      send(`DBGP_CMD_LED_BLOCK, 8'h01);
      chk("led", 8'h00, led_sink_on);
      host.frame(`DBGP_CMD_READ, 8'h00, 1'b1, rep);
      #1;
      chk("reply", 8'h0C, rep);
      chk("oe", 8'h00, debug_data_line_oe);
      send(`DBGP_CMD_LED_BLOCK, 8'h00);
      send(`DBGP_CMD_DISCONNECT, 8'h00);
      chk("halt", 8'h00, core_halt);
      chk("led", 8'h01, led_sink_on);
      // Factory part keeps RAM, user part reloads it.
      for (int l = 0; l < 2; l++) begin
         @(posedge mclk);
         led_request <= 1'b0;
         life_state <= l[1:0];
         send(`DBGP_CMD_CONNECT, 8'h00);
         fork
            send(`DBGP_CMD_RESET, 8'h00);
            begin
               wait_on(0, 1'b1);
               chk("image", l[7:0], boot_load_user);
               chk("dreset", 8'h01, digital_reset);
            end
         join
         send(`DBGP_CMD_DISCONNECT, 8'h00);
      end
      @(posedge mclk);
      life_state <= `DBGP_LIFE_RUN;
      send(`DBGP_CMD_CONNECT, 8'h00);
      chk("session", 8'h00, session_active);
      @(posedge mclk);
      life_state <= `DBGP_LIFE_USER;
      debug_disable <= 1'b1;
      send(`DBGP_CMD_CONNECT, 8'h00);
      chk("session", 8'h00, session_active);
      @(posedge mclk);
      shutdown_req <= 1'b1;
      wait_on(1, 1'b0);
      @(posedge mclk);
      shutdown_req <= 1'b0;
      wake_any_low <= 1'b1;
      wait_on(1, 1'b1);
      chk("power", 8'h01, digital_power_on);
      @(posedge mclk);
      user_pin4_oe <= 1'b1;
      wait_on(2, 1'b0);
      @(posedge mclk);
      user_pin4_out <= 1'b1;
      wait_on(2, 1'b1);
      chk("pin4", 8'h01, user_pin4_in);
      wrap_up();
   end
endmodule
`default_nettype wire
